// [verilog/lfd_pkg.sv]
/*
 * Constants for the lock flag, special-cycle and bus-hold controller.
 * Assumes a processor external cycle interface sampled on i_clk_sys.
 */
package lfd_pkg;
    // Cycle request codes (processor to system)
    localparam logic [2:0] REQ_IDLE       = 3'h0;
    localparam logic [2:0] REQ_MEMORY_REQUEST_A    = 3'h1;
    localparam logic [2:0] REQ_FETCH      = 3'h2;
    localparam logic [2:0] REQ_FETCH_M    = 3'h3;
    localparam logic [2:0] REQ_READ_BLOCK = 3'h4;
    localparam logic [2:0] REQ_WRITE_BLK  = 3'h5;
    localparam logic [2:0] REQ_LOAD_LOCK  = 3'h6;
    localparam logic [2:0] REQ_STORE_COND = 3'h7;
    // Cycle acknowledge codes (system to processor)
    localparam logic [2:0] ACK_IDLE       = 3'h0;
    localparam logic [2:0] ACK_HARD_ERR   = 3'h1;
    localparam logic [2:0] ACK_SC_FAIL    = 3'h2;
    localparam logic [2:0] ACK_OK         = 3'h4;
    // Read data acknowledge codes
    localparam logic [2:0] RACK_IDLE      = 3'h0;
    localparam logic [2:0] RACK_OK        = 3'h4;
    // Address tag field
    localparam int TAG_HI                 = 33;
    localparam int TAG_LO                 = 5;
    localparam int TAG_W                  = TAG_HI - TAG_LO + 1;
    // Grant release delay: processor waits 2 CPU cycles
    localparam int REL_CPU_CYC            = 2;
    localparam logic [1:0] REL_CNT        = 2'(REL_CPU_CYC);
    localparam logic       LOCK_RST       = 1'b0;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_PROBE = 6'b000010,
        ST_MEM   = 6'b000100,
        ST_ACK   = 6'b001000,
        ST_HOLD  = 6'b010000,
        ST_REL   = 6'b100000
    } lfd_state_t;
endpackage

// [verilog/lfd_ctrl.sv]
/*
 * System-side controller: lock flag for load-locked / store-conditional,
 * external tag probe, special-cycle acknowledge and DMA bus-hold handshake.
 * Assumes memory completes on i_mem_done and tag RAMs answer in one cycle.
 */
// Notes on behaviour
// R1: Processor skips its own cache probe for load-locked; we probe instead.
// R2: Lock flag set as load-locked data is returned.
// R3: Locked cycles compare the full tag address, not only valid/dirty.
// R4: Load-locked request enables tag RAMs; valid match is a hit, dirty sole copy.
// R5: Valid dirty load-locked hit served from external cache.
// R6: Clean hit or miss served from memory; lock set in every case.
// R7: Lock flag always kept; cleared by any other access to the location; the code keeps it set if a load-locked fill completes that cycle.
// R8: Store-conditional arrives as a write-type request without processor probe.
// R9: Held lock: store-conditional done as normal write with probe; lock cleared.
// R10: Dirty store-conditional hit writes cache using the segment mask.
// R11: Store-conditional mask marks at most one segment.
// R12: Lock already clear: answer failure code with no external cycle.
// R13: Memory_request_a, fetch and fetch-modify answered with OK code.
// R14: Memory_request_a decoded without any address qualification.
// R15: DMA asks hold; processor grants and releases its drivers.
// R16: Grant sampled through synchroniser, never on the processor clock edge.
// R17: During hold, address driven in; tag match low means hit.
// R18: DMA probe decides cache or memory source by valid and dirty; the code here acts only on a DMA write hit.
// R19: DMA write hit: cache written dirty and on-chip line invalidated.
// R20: Agent drops hold; wait 2 CPU cycles after grant falls.
// R21: No data enable, write select or acknowledges during DMA access.
// R22: Hold request forwarded only between external cycles.
// R23: Lock flag cleared at reset.
module lfd_ctrl
    import lfd_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic [2:0]       i_cycle_request_code,
    input  wire logic [TAG_W-1:0] i_proc_adr,
    input  wire logic [7:0]       i_write_segment_mask,
    input  wire logic [TAG_W-1:0] i_tag_ram_adr,
    input  wire logic             i_tag_valid,
    input  wire logic             i_tag_dirty,
    input  wire logic             i_tag_match_n,
    input  wire logic             i_bus_hold_grant,
    input  wire logic             i_mem_done,
    input  wire logic             i_dma_req,
    input  wire logic             i_dma_write,
    input  wire logic [TAG_W-1:0] i_dma_adr,
    input  wire logic             i_dma_done,
    input  wire logic             i_snoop_valid,
    input  wire logic [TAG_W-1:0] i_snoop_adr,
    output logic [2:0]            o_cycle_acknowledge_code,
    output logic [2:0]            o_read_data_ack_code,
    output logic                  o_data_drive_enable_n,
    output logic [1:0]            o_data_write_segment_select,
    output logic                  o_bus_hold_request,
    output logic                  o_tag_ram_enable,
    output logic                  o_cache_write,
    output logic                  o_mem_start,
    output logic                  o_mem_write,
    output logic                  o_onchip_cache_invalidate_request,
    output logic [TAG_W-1:0]      o_dma_adr,
    output logic                  o_dma_adr_oe,
    output logic                  o_dma_grant,
    output logic                  o_lock_flag
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [2:0] req_s1_r, req_s2_r;
    logic       grant_s1_r, grant_s2_r;
    logic       dma_s1_r, dma_s2_r;
    logic       done_s1_r, done_s2_r;

    // [R16] Grant changes on the processor clock; two flops before use
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            req_s1_r   <= 3'h0;
            req_s2_r   <= 3'h0;
            grant_s1_r <= 1'b0;
            grant_s2_r <= 1'b0;
            dma_s1_r   <= 1'b0;
            dma_s2_r   <= 1'b0;
            done_s1_r  <= 1'b0;
            done_s2_r  <= 1'b0;
        end else begin
            req_s1_r   <= i_cycle_request_code;
            req_s2_r   <= req_s1_r;
            grant_s1_r <= i_bus_hold_grant;
            grant_s2_r <= grant_s1_r;
            dma_s1_r   <= i_dma_req;
            dma_s2_r   <= dma_s1_r;
            done_s1_r  <= i_mem_done;
            done_s2_r  <= done_s1_r;
        end
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    function automatic logic tag_hit(input logic [TAG_W-1:0] a, input logic [TAG_W-1:0] t,
                                     input logic v);
        tag_hit = v && (a == t);
    endfunction

    lfd_state_t state_r, state_nxt;
    logic       lock_r, lock_nxt;
    logic [1:0] rel_cnt_r, rel_cnt_nxt;
    logic [2:0] cmd_r;

    // [R14] Memory_request_a decoded from the code alone, address ignored
    wire is_special = (req_s2_r == REQ_MEMORY_REQUEST_A) || (req_s2_r == REQ_FETCH)
                    || (req_s2_r == REQ_FETCH_M);
    wire is_ll      = (req_s2_r == REQ_LOAD_LOCK);
    wire is_sc      = (req_s2_r == REQ_STORE_COND);
    // [R3] [R4] Full tag compare against the processor address
    wire proc_hit   = tag_hit(i_proc_adr, i_tag_ram_adr, i_tag_valid);
    // [R17] Processor tag-match pin during hold
    wire dma_hit    = !i_tag_match_n && i_tag_valid;
    wire hit        = (state_r == ST_HOLD) ? dma_hit : proc_hit;
    // [R5] Dirty locked-cycle hit served from cache; clean or miss from memory; no hold output uses it
    wire use_cache  = hit && i_tag_dirty;
    // [R7] Any other agent touching the locked location kills the lock, except in the cycle a load-locked fill completes
    wire snoop_kill = i_snoop_valid && (i_snoop_adr == i_proc_adr);
    wire dma_kill   = (state_r == ST_HOLD) && (i_dma_adr == i_proc_adr);

    // ****************************************************************
    // Control state machine
    // ****************************************************************
    always_comb begin
        state_nxt   = state_r;
        lock_nxt    = lock_r;
        rel_cnt_nxt = rel_cnt_r;
        case (state_r)
            ST_IDLE: begin
                // [R22] Hold only offered between external cycles
                if (dma_s2_r)
                    state_nxt = ST_HOLD;
                else if (is_special)
                    state_nxt = ST_ACK; // [R13]
                else if (is_sc && !lock_r)
                    state_nxt = ST_ACK; // [R12] no probe, no memory cycle
                else if (is_ll || is_sc)
                    state_nxt = ST_PROBE; // [R1] [R8]
            end
            ST_PROBE: state_nxt = ST_MEM;
            ST_MEM: begin
                if (done_s2_r) begin
                    state_nxt = ST_ACK;
                    if (cmd_r == REQ_LOAD_LOCK)
                        lock_nxt = 1'b1; // [R2] [R6]
                    else
                        lock_nxt = 1'b0; // [R9]
                end
            end
            // Stay until the code drains through the synchroniser, or it is taken twice
            ST_ACK:  state_nxt = (req_s2_r == REQ_IDLE) ? ST_IDLE : ST_ACK;
            ST_HOLD: begin
                // [R20] Agent finished and grant seen to fall
                if (!dma_s2_r && !grant_s2_r) begin
                    state_nxt   = ST_REL;
                    rel_cnt_nxt = REL_CNT;
                end
            end
            ST_REL: begin
                if (rel_cnt_r == 2'h0)
                    state_nxt = ST_IDLE;
                else
                    rel_cnt_nxt = rel_cnt_r - 2'h1; // [R20]
            end
            default: state_nxt = ST_IDLE;
        endcase
        // [R7] Kill wins only when no load-locked fill completes this cycle
        if ((snoop_kill || dma_kill) && !(state_r == ST_MEM && done_s2_r
            && cmd_r == REQ_LOAD_LOCK))
            lock_nxt = 1'b0;
    end

    // [R23] Lock cleared on reset
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r   <= ST_IDLE;
            lock_r    <= LOCK_RST;
            rel_cnt_r <= 2'h0;
            cmd_r     <= REQ_IDLE;
        end else begin
            state_r   <= state_nxt;
            lock_r    <= lock_nxt;
            rel_cnt_r <= rel_cnt_nxt;
            if (state_r == ST_IDLE)
                cmd_r <= req_s2_r;
        end
    end

    // ****************************************************************
    // Outputs, all registered
    // ****************************************************************
    wire in_hold  = (state_nxt == ST_HOLD);
    // Acknowledge pulses once on entry, not while the code drains
    wire ack_go   = (state_nxt == ST_ACK) && (state_r != ST_ACK);
    wire sc_fail  = ack_go && (state_r == ST_IDLE) && is_sc;
    wire ll_fill  = (state_r == ST_MEM) && done_s2_r && (cmd_r == REQ_LOAD_LOCK);
    wire sc_write = (state_nxt == ST_MEM) && (cmd_r == REQ_STORE_COND);
    wire [2:0] ack_nxt = !ack_go ? ACK_IDLE : (sc_fail ? ACK_SC_FAIL : ACK_OK);
    // [R11] One segment at most; pick the 128-bit half that holds it
    wire [1:0] wsel_nxt = !sc_write ? 2'b00
                        : ((|i_write_segment_mask[7:4]) ? 2'b10 : 2'b01);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cycle_acknowledge_code          <= ACK_IDLE;
            o_read_data_ack_code              <= RACK_IDLE;
            o_data_drive_enable_n             <= 1'b1;
            o_data_write_segment_select       <= 2'b00;
            o_bus_hold_request                <= 1'b0;
            o_tag_ram_enable                  <= 1'b0;
            o_cache_write                     <= 1'b0;
            o_mem_start                       <= 1'b0;
            o_mem_write                       <= 1'b0;
            o_onchip_cache_invalidate_request <= 1'b0;
            o_dma_adr                         <= '0;
            o_dma_adr_oe                      <= 1'b0;
            o_dma_grant                       <= 1'b0;
            o_lock_flag                       <= LOCK_RST;
        end else begin
            // [R21] Acknowledges and data strobes stay idle in hold
            o_cycle_acknowledge_code    <= in_hold ? ACK_IDLE : ack_nxt;
            o_read_data_ack_code        <= ll_fill ? RACK_OK : RACK_IDLE;
            o_data_drive_enable_n       <= !(sc_write && !in_hold);
            o_data_write_segment_select <= in_hold ? 2'b00 : wsel_nxt;
            // [R15] [R22] Request raised only from idle, dropped when agent ends
            o_bus_hold_request          <= (state_r == ST_IDLE && dma_s2_r)
                                         || (state_r == ST_HOLD && dma_s2_r);
            o_tag_ram_enable            <= (state_nxt == ST_PROBE) || in_hold;
            // [R10] [R19] Dirty store-conditional hit or any DMA write hit writes the cache
            o_cache_write               <= (state_r == ST_PROBE && use_cache
                                            && cmd_r == REQ_STORE_COND)
                                         || (state_r == ST_HOLD && grant_s2_r
                                            && i_dma_write && dma_hit);
            // [R5] Dirty hit served by the cache alone; memory would hold stale data
            o_mem_start                 <= (state_r == ST_PROBE) && !use_cache;
            o_mem_write                 <= (state_r == ST_PROBE)
                                         && (cmd_r == REQ_STORE_COND) && !use_cache;
            o_onchip_cache_invalidate_request <= (state_r == ST_HOLD) && grant_s2_r
                                         && i_dma_write && dma_hit; // [R19]
            o_dma_adr                   <= i_dma_adr;
            // [R17] Drive address only once the grant is seen
            o_dma_adr_oe                <= (state_r == ST_HOLD) && grant_s2_r && dma_s2_r;
            o_dma_grant                 <= (state_r == ST_HOLD) && grant_s2_r;
            o_lock_flag                 <= lock_nxt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_sc_fail_code: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R12]
        (state_r == ST_IDLE && !dma_s2_r && is_sc && !lock_r)
        |=> (o_cycle_acknowledge_code == ACK_SC_FAIL && !o_mem_start))
        else $error("store-conditional without lock not failed");
    a_special_ok: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R13]
        (state_r == ST_IDLE && !dma_s2_r && is_special)
        |=> o_cycle_acknowledge_code == ACK_OK)
        else $error("special cycle not acknowledged OK");
    a_ll_sets_lock: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R2]
        ll_fill |=> (lock_r && o_read_data_ack_code == RACK_OK))
        else $error("load-locked fill did not set lock");
    a_sc_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R9]
        (state_r == ST_MEM && done_s2_r && cmd_r == REQ_STORE_COND) |=> !lock_r)
        else $error("store-conditional left lock set");
    a_hold_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R21]
        (state_r == ST_HOLD) |-> (o_cycle_acknowledge_code == ACK_IDLE
        && o_data_drive_enable_n && o_read_data_ack_code == RACK_IDLE))
        else $error("acknowledge driven during hold");
    a_rel_wait: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R20]
        (state_r == ST_HOLD && state_nxt == ST_REL) |=> (state_r == ST_REL) [*3]
        ##1 state_r == ST_IDLE)
        else $error("release wait wrong length");
    a_hold_idle_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R22]
        $rose(o_bus_hold_request) |-> $past(state_r) == ST_IDLE)
        else $error("hold raised mid cycle");
    a_adr_in_grant: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R15]
        o_dma_adr_oe |-> o_dma_grant)
        else $error("address driven without grant");
    a_ll_probe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R4]
        (state_r == ST_IDLE && !dma_s2_r && is_ll) |=> ##[0:1] o_tag_ram_enable)
        else $error("tag RAMs not enabled for load-locked");
    a_reset_lock: assert property (@(posedge i_clk_sys) // [R23]
        $rose(i_rst_b) |-> !lock_r)
        else $error("lock not clear after reset");
    a_dirty_no_mem: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R5]
        (state_r == ST_PROBE && cmd_r == REQ_LOAD_LOCK && i_tag_valid && i_tag_dirty
        && i_tag_ram_adr == i_proc_adr) |=> !o_mem_start)
        else $error("dirty load-locked hit sent to memory");
    a_ack_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // [R13]
        (o_cycle_acknowledge_code != ACK_IDLE) |=> o_cycle_acknowledge_code == ACK_IDLE)
        else $error("acknowledge held longer than one cycle");

    c_ll: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) ll_fill);
    c_sc_fail: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) sc_fail);
    c_hold: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_dma_grant);
    c_special: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state_r == ST_IDLE && is_special);
    c_dirty_ll: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state_r == ST_PROBE && use_cache && cmd_r == REQ_LOAD_LOCK);
endmodule

// [verif/lfd_cpu_model.sv]
/*
 * Behavioural processor on the far side of the lock flag and hold controller.
 * Assumes the controller answers every request on the acknowledge code.
 */
module lfd_cpu_model
    import lfd_pkg::*;
#(
    parameter logic [TAG_W-1:0] CACHED_TAG = 29'h0abc_d12
)
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic             i_bus_hold_request,
    input  wire logic [2:0]       i_cycle_acknowledge_code,
    input  wire logic [2:0]       i_read_data_ack_code,
    input  wire logic [TAG_W-1:0] i_dma_adr,
    input  wire logic             i_dma_adr_oe,
    output logic      [2:0]       o_cycle_request_code,
    output logic      [TAG_W-1:0] o_proc_adr,
    output logic      [7:0]       o_write_segment_mask,
    output logic                  o_bus_hold_grant,
    output logic                  o_tag_match_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [TAG_W-1:0] adr_r;
    logic [1:0]       rel_r;

    // Released pins show a changed value, never the last one
    assign o_proc_adr = (o_bus_hold_grant || rel_r != 2'h0) ? ~adr_r : adr_r;
    assign o_tag_match_n = !(o_bus_hold_grant && i_dma_adr_oe && i_dma_adr == CACHED_TAG);

    initial begin
        o_cycle_request_code = REQ_IDLE;
        o_write_segment_mask = 8'h00;
        adr_r = '0;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_hold_grant <= 1'b0;
            rel_r <= 2'h0;
        end else begin
            o_bus_hold_grant <= i_bus_hold_request;
            if (o_bus_hold_grant && !i_bus_hold_request)
                rel_r <= REL_CNT;
            else if (rel_r != 2'h0)
                rel_r <= rel_r - 2'h1;
        end
    end

    // Locked cycles go straight to the pins, no internal cache probe
    task automatic issue(input logic [2:0] code, input logic [TAG_W-1:0] adr,
                         input logic [7:0] mask, output logic [2:0] ack,
                         output logic [2:0] rack);
        ack = ACK_IDLE;
        rack = RACK_IDLE;
        @(posedge i_clk_sys);
        o_cycle_request_code <= code;
        adr_r <= adr;
        o_write_segment_mask <= mask;
        for (int i = 0; i < 200 && ack === ACK_IDLE; i++) begin
            @(negedge i_clk_sys);
            if (i_read_data_ack_code !== RACK_IDLE)
                rack = i_read_data_ack_code;
            ack = i_cycle_acknowledge_code;
        end
        @(posedge i_clk_sys);
        o_cycle_request_code <= REQ_IDLE;
        o_write_segment_mask <= 8'h00;
        // Idle gap lets the request synchroniser drain
        repeat (4) @(posedge i_clk_sys);
    endtask
endmodule

// [verif/lock_flag_and_dma_hold_control_test.sv]
/*
 * Self-checking bench for the lock flag, special-cycle and bus-hold controller.
 * Assumes lfd_cpu_model stands in for the processor.
 */
module lock_flag_and_dma_hold_control_test
    import lfd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [TAG_W-1:0] HIT = 29'h0abc_d12;
    logic             clk, rst_b, clr, tag_v, tag_d, done, dma_req, dma_wr, dma_done, snp_v;
    logic [TAG_W-1:0] tag_adr, dma_adr, pa, cpu_adr, dma_out, snp_adr;
    logic [2:0]       req, ack, rack, ack_v, rack_v;
    logic [7:0]       mask;
    logic [1:0]       sel;
    logic [7:0]       seen;
    logic             grant, match_n, oe_n, hold, tag_en, cwr, mst, mwr, inv, adr_oe, dgnt;
    logic             lock;
    int               errors, n_compared, cyc;

    lfd_ctrl dut_u (.i_clk_sys(clk), .i_rst_b(rst_b), .i_cycle_request_code(req),
        .i_proc_adr(cpu_adr), .i_write_segment_mask(mask), .i_tag_ram_adr(tag_adr),
        .i_tag_valid(tag_v), .i_tag_dirty(tag_d), .i_tag_match_n(match_n),
        .i_bus_hold_grant(grant), .i_mem_done(done), .i_dma_req(dma_req),
        .i_dma_write(dma_wr), .i_dma_adr(dma_adr), .i_dma_done(dma_done),
        .i_snoop_valid(snp_v), .i_snoop_adr(snp_adr), .o_cycle_acknowledge_code(ack),
        .o_read_data_ack_code(rack), .o_data_drive_enable_n(oe_n),
        .o_data_write_segment_select(sel), .o_bus_hold_request(hold),
        .o_tag_ram_enable(tag_en), .o_cache_write(cwr), .o_mem_start(mst),
        .o_mem_write(mwr), .o_onchip_cache_invalidate_request(inv), .o_dma_adr(dma_out),
        .o_dma_adr_oe(adr_oe), .o_dma_grant(dgnt), .o_lock_flag(lock));

    lfd_cpu_model #(.CACHED_TAG(HIT)) cpu_u (.i_clk_sys(clk), .i_rst_b(rst_b),
        .i_bus_hold_request(hold), .i_cycle_acknowledge_code(ack),
        .i_read_data_ack_code(rack), .i_dma_adr(dma_out), .i_dma_adr_oe(adr_oe),
        .o_cycle_request_code(req), .o_proc_adr(cpu_adr), .o_write_segment_mask(mask),
        .o_bus_hold_grant(grant), .o_tag_match_n(match_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ********************************
    // Memory stand-in and event capture
    // ********************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end

    always @(posedge clk) begin
        if (ack != ACK_IDLE)
            done <= 1'b0;
        else if (tag_en || mst)
            done <= 1'b1;
        if (clr)
            seen <= '0;
        else
            seen <= seen | {mwr, dgnt && (ack != 3'h0 || rack != 3'h0 || !oe_n || sel != 2'h0),
                            !oe_n, inv, cwr, mst, sel};
    end

    // ********************************
    // Compare, verdict and request tasks
    // ********************************
    task automatic chk_code(input logic [2:0] got, input logic [2:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_code({2'b00, got}, {2'b00, exp});
    endtask

    task automatic print_verdict();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cyc_req(input logic [2:0] code, input logic [7:0] m, input logic d,
                           input logic [TAG_W-1:0] t);
        @(posedge clk);
        clr <= 1'b1;
        tag_d <= d;
        tag_adr <= t;
        @(posedge clk);
        clr <= 1'b0;
        cpu_u.issue(code, pa, m, ack_v, rack_v);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    // Dirty block with another tag still means memory: full tag compare
    task automatic t_ll(input logic [TAG_W-1:0] t, input logic d);
        cyc_req(REQ_LOAD_LOCK, 8'h00, d, t);
        chk_code(ack_v, ACK_OK);
        chk_code(rack_v, RACK_OK);
        chk_bit(lock, 1'b1);
        chk_bit(seen[2], !(t == HIT && d));
    endtask

    task automatic t_sc(input logic [7:0] m, input logic [1:0] s, input logic held);
        cyc_req(REQ_STORE_COND, m, 1'b1, HIT);
        chk_code(ack_v, held ? ACK_OK : ACK_SC_FAIL);
        chk_bit(seen[3], held);
        chk_bit(seen[5], held);
        chk_bit(seen[7], 1'b0);
        chk_code({1'b0, seen[1:0]}, {1'b0, held ? s : 2'b00});
        chk_bit(lock, 1'b0);
    endtask

    task automatic t_dma(input logic w, input logic [TAG_W-1:0] a, input logic hit);
        @(posedge clk);
        clr <= 1'b1;
        dma_wr <= w;
        dma_adr <= a;
        dma_req <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        for (int i = 0; i < 40 && dgnt !== 1'b1; i++) @(negedge clk);
        chk_bit(hold, 1'b1);
        chk_bit(adr_oe, 1'b1);
        repeat (12) @(negedge clk);
        chk_bit(seen[4], hit);
        chk_bit(seen[6], 1'b0);
        @(posedge clk);
        dma_done <= 1'b1;
        dma_req <= 1'b0;
        for (int i = 0; i < 40 && (hold !== 1'b0 || adr_oe !== 1'b0); i++) @(negedge clk);
        chk_bit(hold, 1'b0);
        chk_bit(adr_oe, 1'b0);
        @(posedge clk);
        dma_done <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        {rst_b, clr, tag_v, tag_d, done, dma_req, dma_wr, dma_done, snp_v} = '0;
        {tag_adr, dma_adr, snp_adr} = '0;
        pa = HIT;
        {errors, n_compared, cyc} = '0;
        seen = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        tag_v <= 1'b1;
        @(negedge clk);
        chk_bit(lock, 1'b0);
        chk_bit(oe_n, 1'b1);
        t_sc(8'h10, 2'b10, 1'b0);
        t_ll(~HIT, 1'b1);
        t_sc(8'h10, 2'b10, 1'b1);
        t_ll(HIT, 1'b0);
        t_sc(8'h03, 2'b01, 1'b1);
        t_sc(8'h03, 2'b01, 1'b0);
        t_ll(~HIT, 1'b0);
        t_ll(HIT, 1'b1);
        // Snoop elsewhere keeps the lock, snoop on the location kills it
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            snp_v <= 1'b1;
            snp_adr <= k[0] ? HIT : ~HIT;
            @(posedge clk);
            snp_v <= 1'b0;
            repeat (4) @(negedge clk);
            chk_bit(lock, !k[0]);
        end
        t_sc(8'h01, 2'b01, 1'b0);
        t_dma(1'b1, HIT, 1'b1);
        t_dma(1'b1, ~HIT, 1'b0);
        for (int k = 0; k < 6; k++) begin
            pa = k[0] ? '1 : 29'h0000_0a5;
            cyc_req(3'(1 + k / 2), 8'h00, 1'b0, HIT);
            chk_code(ack_v, ACK_OK);
        end
        print_verdict();
    end
endmodule
